/* src/nvac_pkg.sv */
// Package of constants for the data EEPROM access control block
package nvac_pkg;
	localparam int NVAC_AW = 8;
	localparam int NVAC_DW = 8;
	localparam int NVAC_DEPTH = 256;
	localparam int NVAC_SELW = 2;
	localparam logic [1:0] NVAC_SEL_ADDR = 2'h0;
	localparam logic [1:0] NVAC_SEL_DATA = 2'h1;
	localparam logic [1:0] NVAC_SEL_CTRL = 2'h2;
	localparam logic [1:0] NVAC_SEL_UNLK = 2'h3;
	localparam int NVAC_B_RD = 0;
	localparam int NVAC_B_WR = 1;
	localparam int NVAC_B_WRITE_ENABLE_GATE = 2;
	localparam int NVAC_B_ERR = 3;
	localparam int NVAC_B_DONE = 4;
	localparam int NVAC_B_PGSEL = 7;
	localparam logic [7:0] NVAC_KEY1 = 8'h55;
	localparam logic [7:0] NVAC_KEY2 = 8'hAA;
	localparam logic [7:0] NVAC_ZERO8 = 8'h00;
	localparam int NVAC_WRITE_TIME_NS = 4000;
	localparam int NVAC_CLK_NS = 100;
	localparam int NVAC_WRITE_CYC = (NVAC_WRITE_TIME_NS + NVAC_CLK_NS - 1) / NVAC_CLK_NS;
	localparam int NVAC_CNTW = 16;
	typedef enum logic [1:0] {
		NVAC_UL_IDLE = 2'b00,
		NVAC_UL_KEY1 = 2'b01,
		NVAC_UL_ARMED = 2'b11
	} nvac_unlock_e;
endpackage

/* src/nvac_if.sv */
// Register access interface between core and EEPROM control
`timescale 1ns/1ps
interface nvac_if;
	import nvac_pkg::*;
	logic [NVAC_SELW-1:0] sel;
	logic wr;
	logic [NVAC_DW-1:0] wdata;
	logic [NVAC_DW-1:0] rdata;
	modport dev (input sel, input wr, input wdata, output rdata);
	modport core (output sel, output wr, output wdata, input rdata);
endinterface

/* src/nvac_dev.sv */
// Data EEPROM access control: registers, unlock sequencer, write timer, array
`timescale 1ns/1ps
module nvac_dev #(
	parameter int WRITE_CYC = nvac_pkg::NVAC_WRITE_CYC
) (
	input wire logic core_clk,
	input wire logic rst_n,
	input wire logic clk_en,
	nvac_if.dev bus,
	output logic [nvac_pkg::NVAC_AW-1:0] nv_address_reg,
	output logic [nvac_pkg::NVAC_DW-1:0] nv_data_reg,
	output logic write_busy,
	output logic nv_done_flag
);
	import nvac_pkg::*;

	logic [NVAC_DW-1:0] mem [NVAC_DEPTH];
	logic [NVAC_AW-1:0] addr_ff, nxt_addr;
	logic [NVAC_DW-1:0] data_ff, nxt_data;
	logic pgsel_ff, nxt_pgsel;
	logic write_enable_gate_ff, nxt_write_enable_gate;
	logic wr_ff, nxt_wr;
	logic done_ff, nxt_done;
	logic err_ff, nxt_err;
	logic [NVAC_CNTW-1:0] cnt_ff, nxt_cnt;
	nvac_unlock_e ul_ff, nxt_ul;
	logic wr_ctrl, wr_unlk, start, finish;
	logic [NVAC_DW-1:0] w;

	assign w = bus.wdata;
	assign wr_ctrl = bus.wr && bus.sel == NVAC_SEL_CTRL;
	assign wr_unlk = bus.wr && bus.sel == NVAC_SEL_UNLK;
	// Gate must already be set from an earlier write, not this one
	assign start = wr_ctrl && !wr_ff && w[NVAC_B_WR] && write_enable_gate_ff
		&& ul_ff == NVAC_UL_ARMED;
	assign finish = wr_ff && cnt_ff == NVAC_CNTW'(1);

	always_comb begin
		nxt_ul = ul_ff;
		if (bus.wr) begin
			// Any other write breaks the sequence, so it must be back to back
			unique case (ul_ff)
				NVAC_UL_IDLE: nxt_ul = (wr_unlk && w == NVAC_KEY1) ? NVAC_UL_KEY1 : NVAC_UL_IDLE;
				NVAC_UL_KEY1: nxt_ul = (wr_unlk && w == NVAC_KEY2) ? NVAC_UL_ARMED :
					(wr_unlk && w == NVAC_KEY1) ? NVAC_UL_KEY1 : NVAC_UL_IDLE;
				NVAC_UL_ARMED: nxt_ul = (wr_unlk && w == NVAC_KEY1) ? NVAC_UL_KEY1 : NVAC_UL_IDLE;
				default: nxt_ul = NVAC_UL_IDLE;
			endcase
		end
	end

	always_comb begin
		nxt_addr = addr_ff;
		nxt_data = data_ff;
		nxt_pgsel = pgsel_ff;
		nxt_write_enable_gate = write_enable_gate_ff;
		nxt_wr = wr_ff;
		nxt_err = err_ff;
		nxt_done = done_ff;
		nxt_cnt = cnt_ff;
		if (!wr_ff) begin
			if (bus.wr && bus.sel == NVAC_SEL_ADDR)
				nxt_addr = w;
			if (bus.wr && bus.sel == NVAC_SEL_DATA)
				nxt_data = w;
			if (wr_ctrl) begin
				nxt_pgsel = w[NVAC_B_PGSEL];
				nxt_write_enable_gate = w[NVAC_B_WRITE_ENABLE_GATE];
				nxt_err = w[NVAC_B_ERR];
				if (w[NVAC_B_RD] && !w[NVAC_B_PGSEL])
					nxt_data = mem[addr_ff];
			end
		end
		if (wr_ctrl && !w[NVAC_B_DONE])
			nxt_done = 1'b0;
		if (start) begin
			nxt_wr = 1'b1;
			nxt_cnt = NVAC_CNTW'(WRITE_CYC);
		end else if (wr_ff) begin
			nxt_cnt = cnt_ff - NVAC_CNTW'(1);
			if (finish) begin
				nxt_wr = 1'b0;
				nxt_done = 1'b1;
			end
		end
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			addr_ff <= NVAC_ZERO8;
			data_ff <= NVAC_ZERO8;
			pgsel_ff <= 1'b0;
			write_enable_gate_ff <= 1'b0;
			wr_ff <= 1'b0;
			err_ff <= 1'b0;
			done_ff <= 1'b0;
			cnt_ff <= '0;
			ul_ff <= NVAC_UL_IDLE;
		end else if (clk_en) begin
			addr_ff <= nxt_addr;
			data_ff <= nxt_data;
			pgsel_ff <= nxt_pgsel;
			write_enable_gate_ff <= nxt_write_enable_gate;
			wr_ff <= nxt_wr;
			err_ff <= nxt_err;
			done_ff <= nxt_done;
			cnt_ff <= nxt_cnt;
			ul_ff <= nxt_ul;
		end
	end

	// Array has no reset, as a real nonvolatile store would not
	always_ff @(posedge core_clk) begin
		if (clk_en && finish)
			mem[addr_ff] <= data_ff;
	end

	always_comb begin
		unique case (bus.sel)
			NVAC_SEL_ADDR: bus.rdata = addr_ff;
			NVAC_SEL_DATA: bus.rdata = data_ff;
			NVAC_SEL_CTRL: begin
				bus.rdata = NVAC_ZERO8;
				bus.rdata[NVAC_B_PGSEL] = pgsel_ff;
				bus.rdata[NVAC_B_DONE] = done_ff;
				bus.rdata[NVAC_B_ERR] = err_ff;
				bus.rdata[NVAC_B_WRITE_ENABLE_GATE] = write_enable_gate_ff;
				bus.rdata[NVAC_B_WR] = wr_ff;
			end
			NVAC_SEL_UNLK: bus.rdata = NVAC_ZERO8;
		endcase
	end

	assign nv_address_reg = addr_ff;
	assign nv_data_reg = data_ff;
	assign write_busy = wr_ff;
	assign nv_done_flag = done_ff;
endmodule

/* src/nvac_core.sv */
// Core-side sequencer issuing read and unlocked write register sequences
`timescale 1ns/1ps
module nvac_core (
	input wire logic core_clk,
	input wire logic rst_n,
	input wire logic clk_en,
	nvac_if.core bus,
	input wire logic rd_req,
	input wire logic wr_req,
	input wire logic [nvac_pkg::NVAC_AW-1:0] req_addr,
	input wire logic [nvac_pkg::NVAC_DW-1:0] req_data,
	output logic req_ready,
	output logic [nvac_pkg::NVAC_DW-1:0] rd_data,
	output logic rd_valid,
	output logic wr_done,
	output logic irq_hold
);
	import nvac_pkg::*;

	typedef enum logic [3:0] {
		NVAC_C_IDLE = 4'b0000,
		NVAC_C_ADDR = 4'b0001,
		NVAC_C_RDSTB = 4'b0011,
		NVAC_C_RDCAP = 4'b0010,
		NVAC_C_DATA = 4'b0110,
		NVAC_C_GATE = 4'b0111,
		NVAC_C_KEY1 = 4'b0101,
		NVAC_C_KEY2 = 4'b0100,
		NVAC_C_WRSTB = 4'b1100,
		NVAC_C_POLL = 4'b1101,
		NVAC_C_CLOSE = 4'b1111
	} nvac_core_e;

	nvac_core_e st_ff, nxt_st;
	logic is_wr_ff, nxt_is_wr;
	logic [NVAC_AW-1:0] a_ff, nxt_a;
	logic [NVAC_DW-1:0] d_ff, nxt_d;
	logic [NVAC_DW-1:0] rd_ff, nxt_rd;
	logic rv_ff, nxt_rv, wd_ff, nxt_wd;

	always_comb begin
		nxt_st = st_ff;
		nxt_is_wr = is_wr_ff;
		nxt_a = a_ff;
		nxt_d = d_ff;
		nxt_rd = rd_ff;
		nxt_rv = 1'b0;
		nxt_wd = 1'b0;
		bus.wr = 1'b0;
		bus.sel = NVAC_SEL_ADDR;
		bus.wdata = NVAC_ZERO8;
		unique case (st_ff)
			NVAC_C_IDLE: if (rd_req || wr_req) begin
				nxt_is_wr = wr_req && !rd_req;
				nxt_a = req_addr;
				nxt_d = req_data;
				nxt_st = NVAC_C_ADDR;
			end
			NVAC_C_ADDR: begin
				bus.wr = 1'b1;
				bus.wdata = a_ff;
				nxt_st = is_wr_ff ? NVAC_C_DATA : NVAC_C_RDSTB;
			end
			NVAC_C_RDSTB: begin
				bus.wr = 1'b1;
				bus.sel = NVAC_SEL_CTRL;
				bus.wdata[NVAC_B_RD] = 1'b1;
				nxt_st = NVAC_C_RDCAP;
			end
			NVAC_C_RDCAP: begin
				bus.sel = NVAC_SEL_DATA;
				nxt_rd = bus.rdata;
				nxt_rv = 1'b1;
				nxt_st = NVAC_C_IDLE;
			end
			NVAC_C_DATA: begin
				bus.wr = 1'b1;
				bus.sel = NVAC_SEL_DATA;
				bus.wdata = d_ff;
				nxt_st = NVAC_C_GATE;
			end
			NVAC_C_GATE: begin
				bus.wr = 1'b1;
				bus.sel = NVAC_SEL_CTRL;
				bus.wdata[NVAC_B_WRITE_ENABLE_GATE] = 1'b1;
				nxt_st = NVAC_C_KEY1;
			end
			NVAC_C_KEY1: begin
				bus.wr = 1'b1;
				bus.sel = NVAC_SEL_UNLK;
				bus.wdata = NVAC_KEY1;
				nxt_st = NVAC_C_KEY2;
			end
			NVAC_C_KEY2: begin
				bus.wr = 1'b1;
				bus.sel = NVAC_SEL_UNLK;
				bus.wdata = NVAC_KEY2;
				nxt_st = NVAC_C_WRSTB;
			end
			NVAC_C_WRSTB: begin
				bus.wr = 1'b1;
				bus.sel = NVAC_SEL_CTRL;
				bus.wdata[NVAC_B_WRITE_ENABLE_GATE] = 1'b1;
				bus.wdata[NVAC_B_WR] = 1'b1;
				nxt_st = NVAC_C_POLL;
			end
			NVAC_C_POLL: begin
				bus.sel = NVAC_SEL_CTRL;
				if (!bus.rdata[NVAC_B_WR]) nxt_st = NVAC_C_CLOSE;
			end
			NVAC_C_CLOSE: begin
				// Drops the gate and acknowledges the done flag together
				bus.wr = 1'b1;
				bus.sel = NVAC_SEL_CTRL;
				nxt_wd = 1'b1;
				nxt_st = NVAC_C_IDLE;
			end
			default: nxt_st = NVAC_C_IDLE;
		endcase
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			st_ff <= NVAC_C_IDLE;
			is_wr_ff <= 1'b0;
			a_ff <= NVAC_ZERO8;
			d_ff <= NVAC_ZERO8;
			rd_ff <= NVAC_ZERO8;
			rv_ff <= 1'b0;
			wd_ff <= 1'b0;
		end else if (clk_en) begin
			st_ff <= nxt_st;
			is_wr_ff <= nxt_is_wr;
			a_ff <= nxt_a;
			d_ff <= nxt_d;
			rd_ff <= nxt_rd;
			rv_ff <= nxt_rv;
			wd_ff <= nxt_wd;
		end
	end

	assign req_ready = st_ff == NVAC_C_IDLE;
	assign rd_data = rd_ff;
	assign rd_valid = rv_ff;
	assign wr_done = wd_ff;
	// Interrupts held off from the first key write through the strobe
	assign irq_hold = st_ff == NVAC_C_KEY1 || st_ff == NVAC_C_KEY2
		|| st_ff == NVAC_C_WRSTB;
endmodule

/* verif/nvac_props.sv */
// Checker of the register bus between core sequencer and EEPROM control
`timescale 1ns/1ps
module nvac_props (
	input wire logic core_clk,
	input wire logic rst_n,
	input wire logic [nvac_pkg::NVAC_SELW-1:0] sel,
	input wire logic wr,
	input wire logic [nvac_pkg::NVAC_DW-1:0] wdata,
	input wire logic [nvac_pkg::NVAC_DW-1:0] rdata
);
	import nvac_pkg::*;
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rst_n);
	logic [1:0] ul_ff;
	logic [1:0] nxt_ul;
	logic ctl;
	assign ctl = sel == NVAC_SEL_CTRL;
	logic [NVAC_DW-1:0] dseen_ff;
	logic dvalid_ff;
	// Last byte seen on a plain data read, dropped when a strobe or data write may move it
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			dseen_ff <= NVAC_ZERO8;
			dvalid_ff <= 1'b0;
		end else if (wr && (sel == NVAC_SEL_DATA || (ctl && wdata[NVAC_B_RD]))) begin
			dvalid_ff <= 1'b0;
		end else if (sel == NVAC_SEL_DATA && !wr) begin
			dseen_ff <= rdata;
			dvalid_ff <= 1'b1;
		end
	end
	// Mirror of the unlock progress as seen on the bus
	always_comb begin
		nxt_ul = ul_ff;
		if (wr) begin
			nxt_ul = 2'h0;
			if (sel == NVAC_SEL_UNLK && wdata == NVAC_KEY1) nxt_ul = 2'h1;
			if (sel == NVAC_SEL_UNLK && wdata == NVAC_KEY2 && ul_ff == 2'h1) nxt_ul = 2'h2;
		end
	end
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) ul_ff <= 2'h0;
		else ul_ff <= nxt_ul;
	end
	sequence key_pair;
		wr && sel == NVAC_SEL_UNLK && wdata == NVAC_KEY1 ##1
		wr && sel == NVAC_SEL_UNLK && wdata == NVAC_KEY2;
	endsequence
	sequence start_wr;
		wr && ctl && wdata[NVAC_B_WR] && !rdata[NVAC_B_WR];
	endsequence
	// Busy bit seen rising between two control accesses
	sequence wr_rise;
		ctl && $past(ctl) && !$past(rdata[NVAC_B_WR]) && rdata[NVAC_B_WR];
	endsequence
	rd_zero_a: assert property (ctl |-> !rdata[NVAC_B_RD])
		else $error("read strobe not self clearing");
	gate_held_a: assert property (
		ctl && $past(ctl) && !$past(wr) && $past(rdata[NVAC_B_WRITE_ENABLE_GATE]) |-> rdata[NVAC_B_WRITE_ENABLE_GATE])
		else $error("gate cleared by hardware");
	done_held_a: assert property (
		ctl && $past(ctl) && !$past(wr) && $past(rdata[NVAC_B_DONE]) |-> rdata[NVAC_B_DONE])
		else $error("done flag cleared by hardware");
	wr_end_done_a: assert property (
		ctl && $past(ctl) && !$past(wr) && $past(rdata[NVAC_B_WR]) && !rdata[NVAC_B_WR]
		|-> rdata[NVAC_B_DONE])
		else $error("write end without done flag");
	unlock_start_a: assert property (key_pair ##1 start_wr |=> !ctl || rdata[NVAC_B_WR])
		else $error("unlocked write did not start");
	wr_blocked_a: assert property (
		wr_rise |-> $past(wr && wdata[NVAC_B_WR]) && $past(ul_ff) == 2'h2)
		else $error("write started without unlock");
	both_set_a: assert property (wr_rise |-> $past(rdata[NVAC_B_WRITE_ENABLE_GATE]))
		else $error("write started with gate in same write");
	data_held_a: assert property (sel == NVAC_SEL_DATA && dvalid_ff |-> rdata == dseen_ff)
		else $error("data register changed without access");
endmodule

/* verif/data_eeprom_access_control_tb.sv */
// Bench for the core and device pair plus a lone device driven directly
`timescale 1ns/1ps
module data_eeprom_access_control_tb;
	import nvac_pkg::*;
	localparam int WC = 20;
	localparam logic [1:0] SA = NVAC_SEL_ADDR;
	localparam logic [1:0] SD = NVAC_SEL_DATA;
	localparam logic [1:0] SC = NVAC_SEL_CTRL;
	localparam logic [1:0] SU = NVAC_SEL_UNLK;
	logic core_clk = 1'b0;
	logic rst_n = 1'b0;
	logic clk_en = 1'b1;
	logic irq_hold;
	int icnt = 0;
	logic rd_req = 1'b0;
	logic wr_req = 1'b0;
	logic [7:0] req_addr = 8'h00;
	logic [7:0] req_data = 8'h00;
	logic req_ready, rd_valid, wr_done, busy_a, done_a, busy_b, done_b;
	logic [7:0] rd_data, addr_a, data_a, addr_b, data_b;
	int error_cnt = 0;
	int checks_done = 0;
	int cyc = 0;
	int bcnt = 0;
	nvac_if bus_a();
	nvac_if bus_b();
	initial begin
		bus_b.sel = 2'h0;
		bus_b.wr = 1'b0;
		bus_b.wdata = 8'h00;
		forever #50 core_clk = ~core_clk;
	end
	nvac_dev #(.WRITE_CYC(WC)) nvac_dev_inst (.core_clk(core_clk), .rst_n(rst_n),
		.clk_en(clk_en), .bus(bus_a.dev), .nv_address_reg(addr_a), .nv_data_reg(data_a),
		.write_busy(busy_a), .nv_done_flag(done_a));
	// Second device lets the bench break the unlock rules on purpose
	nvac_dev #(.WRITE_CYC(WC)) nvac_dev_inst_b (.core_clk(core_clk), .rst_n(rst_n),
		.clk_en(clk_en), .bus(bus_b.dev), .nv_address_reg(addr_b), .nv_data_reg(data_b),
		.write_busy(busy_b), .nv_done_flag(done_b));
	nvac_core nvac_core_inst (.core_clk(core_clk), .rst_n(rst_n), .clk_en(clk_en),
		.bus(bus_a.core), .rd_req(rd_req), .wr_req(wr_req), .req_addr(req_addr),
		.req_data(req_data), .req_ready(req_ready), .rd_data(rd_data),
		.rd_valid(rd_valid), .wr_done(wr_done), .irq_hold(irq_hold));
	nvac_props nvac_props_inst (.core_clk(core_clk), .rst_n(rst_n), .sel(bus_a.sel),
		.wr(bus_a.wr), .wdata(bus_a.wdata), .rdata(bus_a.rdata));
	task print_verdict();
		if (error_cnt == 0 && checks_done > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask
	always @(posedge core_clk) begin
		cyc++;
		if (cyc == 3000) begin
			error_cnt++;
			print_verdict();
		end
	end
	// Levels counted mid-cycle, where registered outputs have settled
	always @(negedge core_clk) begin
		if (busy_b === 1'b1) bcnt++;
		if (irq_hold === 1'b1) icnt++;
	end
	task ck(input logic [7:0] got, input logic [7:0] exp);
		checks_done++;
		if (got !== exp) begin
			error_cnt++;
			$display("unexpected at %0t: got %h want %h", $time, got, exp);
		end
	endtask
	task bw(input logic [1:0] s, input logic [7:0] d);
		@(negedge core_clk);
		bus_b.sel = s;
		bus_b.wr = 1'b1;
		bus_b.wdata = d;
		@(negedge core_clk);
		bus_b.wr = 1'b0;
	endtask
	task ckr(input logic [1:0] s, input logic [7:0] exp);
		@(negedge core_clk);
		bus_b.sel = s;
		#1 ck(bus_b.rdata, exp);
	endtask
	task creq(input logic w, input logic [7:0] a, input logic [7:0] d);
		int i;
		@(negedge core_clk);
		for (i = 0; i < 50 && req_ready !== 1'b1; i++) @(negedge core_clk);
		wr_req = w;
		rd_req = !w;
		req_addr = a;
		req_data = d;
		@(negedge core_clk);
		wr_req = 1'b0;
		rd_req = 1'b0;
		for (i = 0; i < 100 && (w ? wr_done : rd_valid) !== 1'b1; i++) @(negedge core_clk);
		ck({7'h00, w ? wr_done : rd_valid}, 8'h01);
	endtask
	initial begin
		repeat (6) @(negedge core_clk);
		rst_n = 1'b1;
		ckr(SC, 8'h00);
		bw(SU, NVAC_KEY1);
		bw(SU, NVAC_KEY2);
		bw(SC, 8'h06);
		ckr(SC, 8'h04);
		bw(SC, 8'h06);
		ckr(SC, 8'h04);
		bw(SU, NVAC_KEY1);
		bw(SD, 8'h11);
		bw(SU, NVAC_KEY2);
		bw(SC, 8'h06);
		ckr(SC, 8'h04);
		bw(SA, 8'h10);
		bw(SD, 8'h5A);
		bw(SU, NVAC_KEY1);
		bw(SU, NVAC_KEY2);
		bcnt = 0;
		bw(SC, 8'h06);
		ckr(SC, 8'h06);
		// Changes while busy must bounce off
		bw(SA, 8'h20);
		bw(SD, 8'h00);
		bw(SC, 8'h00);
		ck(addr_b, 8'h10);
		ck(data_b, 8'h5A);
		ckr(SC, 8'h06);
		for (int i = 0; i < 40 && busy_b !== 1'b0; i++) @(negedge core_clk);
		ck(8'(bcnt), 8'(WC));
		ckr(SC, 8'h14);
		repeat (5) @(negedge core_clk);
		ckr(SC, 8'h14);
		bw(SD, 8'h00);
		bw(SC, 8'h15);
		ck(data_b, 8'h5A);
		ckr(SC, 8'h14);
		bw(SA, 8'h20);
		ck(data_b, 8'h5A);
		bw(SD, 8'h00);
		bw(SC, 8'h81);
		ck(data_b, 8'h00);
		// An address write while the enable is low must leave the address register alone
		@(negedge core_clk);
		clk_en = 1'b0;
		bw(SA, 8'h77);
		clk_en = 1'b1;
		ck(addr_b, 8'h20);
		creq(1'b1, 8'h33, 8'hC3);
		ck(data_a, 8'hC3);
		ck(addr_a, 8'h33);
		ck({6'h00, busy_a, done_a}, 8'h00);
		ck(8'(icnt), 8'h03);
		creq(0, 8'h33, 8'h00);
		ck(rd_data, 8'hC3);
		creq(1'b1, 8'h34, 8'h3C);
		creq(0, 8'h34, 8'h00);
		ck(rd_data, 8'h3C);
		creq(0, 8'h33, 8'h00);
		ck(rd_data, 8'hC3);
		print_verdict();
	end
endmodule
